// File: src/reset_state_initializer.sv
// reset sequencer that forces post-reset register state and loads the program counter
// ------------------------------------------------------------
// Behaviour
// RULE_01 - load counter from vector bytes 0000H, 0001H
// RULE_02 - counter undefined during reset and stabilization
// RULE_03 - status word resets to 02H; stack undefined
// RULE_04 - data memory and registers not initialized
// RULE_05 - directions FFH, output latches 00H
// RULE_06 - masks FFH, request flags 00H
// RULE_07 - key return and edge modes 00H
// RULE_08 - serial transmit shift register FFH
// RULE_09 - serial mode, status, baud 00H
// RULE_10 - timer count, mode 00H; compare undefined
// RULE_11 - watchdog clock select and mode 00H
// RULE_12 - lcd mode, clock, alternate switch 00H
// RULE_13 - watch timer mode 00H, timer stopped
// RULE_14 - programming entry puts pins in reset state
// RULE_15 - pin and watchdog reset act identically
// RULE_16 - run only after 2^15 clock stabilization
// RULE_17 - pins high impedance during reset and stabilization
// RULE_18 - watchdog reset clears itself automatically
// RULE_19 - defined registers held while reset asserted
// RULE_20 - reset request synchronized before release
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module reset_state_initializer
#(
  parameter int STAB_CYCLES = reset_init_pkg::STAB_CYCLES
)
(
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic                          resetPinN,
  input  wire logic                          watchdogOverflow,
  input  wire logic                          programmingEntry,
  input  wire logic [7:0]                    vectorData,
  input  wire reset_init_pkg::cpu_write_t    cpuWrite,
  input  wire logic [2:0]                    portSel,
  input  wire logic                          wrDirection,
  input  wire logic                          wrLatch,
  input  wire reset_init_pkg::cleared_regs_t clearedWrData,
  input  wire reset_init_pkg::cleared_regs_t clearedWrEn,
  output logic [15:0]                        vectorAddr,
  output logic                               vectorRead,
  output logic [15:0]                        program_counter,
  output logic                               programCounterValid,
  output logic                               cpuRun,
  output logic                               pinsHighZ,
  output logic                               internalReset,
  output logic [7:0]                         stack_pointer,
  output logic [7:0]                         processor_status_word,
  output logic [7:0]                         serial_transmit_shift_register,
  output logic [7:0]                         byte_timer_compare_register,
  output logic [15:0]                        interrupt_mask_register,
  output logic [15:0]                        interrupt_request_register,
  output logic [8*reset_init_pkg::NUM_PORTS-1:0] port_direction_register,
  output logic [8*reset_init_pkg::NUM_PORTS-1:0] portOutputLatch,
  output reset_init_pkg::cleared_regs_t      clearedRegs
);

  // ------------------------------------------------------------
  // reset request merge and synchronization
  // ------------------------------------------------------------
  logic pinN_q1;
  logic pinN_q2;
  logic wdog_q1;
  logic wdog_q2;
  logic syncRstN;
  logic requestN;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinN_q1 <= 1'b0;
      pinN_q2 <= 1'b0;
      wdog_q1 <= 1'b0;
      wdog_q2 <= 1'b0;
    end
    else
    begin
      pinN_q1 <= resetPinN;
      pinN_q2 <= pinN_q1;
      wdog_q1 <= watchdogOverflow;
      wdog_q2 <= wdog_q1;
    end
  end

  // watchdog overflow is a pulse: it resets and releases itself, no outside action [RULE_18]
  // both sources feed one request, so their effect is identical [RULE_15]
  assign requestN = pinN_q2 & ~wdog_q2 & ~programmingEntry;

  reset_sync u_sync
  (
    .clk      (clk),
    .arst_n   (arst_n),
    .requestN (requestN),
    .syncRstN (syncRstN)
  ); // [RULE_20]

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  reset_init_pkg::seq_state_t state_q;
  reset_init_pkg::seq_state_t state_d;
  logic [reset_init_pkg::STAB_WIDTH-1:0] count_q;
  logic [reset_init_pkg::STAB_WIDTH-1:0] count_d;
  logic [15:0] pc_d;
  logic        holdReset;

  assign holdReset = ~syncRstN; // [RULE_19]

  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    pc_d    = program_counter;
    if (holdReset)
    begin
      state_d = reset_init_pkg::ST_RESET;
      count_d = '0;
    end
    else
    begin
      unique case (state_q)
        reset_init_pkg::ST_RESET:
        begin
          state_d = reset_init_pkg::ST_STABILIZE;
          count_d = '0;
        end
        reset_init_pkg::ST_STABILIZE:
        begin
          count_d = count_q + 1'b1;
          if (count_q == reset_init_pkg::STAB_WIDTH'(STAB_CYCLES - 1))
            state_d = reset_init_pkg::ST_FETCH_LOW; // [RULE_16]
        end
        reset_init_pkg::ST_FETCH_LOW:
        begin
          pc_d[7:0] = vectorData; // [RULE_01]
          state_d   = reset_init_pkg::ST_FETCH_HIGH;
        end
        reset_init_pkg::ST_FETCH_HIGH:
        begin
          pc_d[15:8] = vectorData; // [RULE_01]
          state_d    = reset_init_pkg::ST_RUN;
        end
        reset_init_pkg::ST_RUN:
          state_d = reset_init_pkg::ST_RUN;
        // three unused codes fall back to a fresh reset pass
        default:
          state_d = reset_init_pkg::ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q         <= reset_init_pkg::ST_RESET;
      count_q         <= '0;
      program_counter <= 16'h0000;
    end
    else
    begin
      state_q         <= state_d;
      count_q         <= count_d;
      program_counter <= pc_d;
    end
  end

  // ------------------------------------------------------------
  // status outputs, all registered
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vectorAddr          <= reset_init_pkg::VECTOR_LOW_ADDR;
      vectorRead          <= 1'b0;
      programCounterValid <= 1'b0;
      cpuRun              <= 1'b0;
      pinsHighZ           <= 1'b1;
      internalReset       <= 1'b1;
    end
    else
    begin
      vectorAddr <= (state_d == reset_init_pkg::ST_FETCH_HIGH) ?
                    reset_init_pkg::VECTOR_HIGH_ADDR : reset_init_pkg::VECTOR_LOW_ADDR;
      vectorRead <= (state_d == reset_init_pkg::ST_FETCH_LOW) ||
                    (state_d == reset_init_pkg::ST_FETCH_HIGH);
      // counter flagged undefined until both vector bytes are in [RULE_02]
      programCounterValid <= (state_d == reset_init_pkg::ST_RUN);
      cpuRun              <= (state_d == reset_init_pkg::ST_RUN);
      // pins float from reset until stabilization is over [RULE_17]
      pinsHighZ     <= (state_d == reset_init_pkg::ST_RESET) ||
                       (state_d == reset_init_pkg::ST_STABILIZE);
      internalReset <= holdReset;
    end
  end

  // ------------------------------------------------------------
  // cpu and peripheral registers
  // ------------------------------------------------------------
  // stack pointer and timer compare carry no reset: they keep old contents [RULE_03] [RULE_10]
  // data memory and general registers live outside and are never touched [RULE_04]
  always_ff @(posedge clk)
  begin
    if (!holdReset && cpuWrite.wrStackPointer)
      stack_pointer <= cpuWrite.wrData;
    if (!holdReset && cpuWrite.wrCompare)
      byte_timer_compare_register <= cpuWrite.wrData;
  end

  reset_byte_reg #(.RESET_VALUE(reset_init_pkg::STATUS_WORD_RST)) u_psw
  (
    .clk       (clk),
    .arst_n    (arst_n),
    .holdReset (holdReset),
    .wrEn      (cpuWrite.wrStatusWord),
    .wrData    (cpuWrite.wrData),
    .value     (processor_status_word)
  ); // [RULE_03]

  reset_byte_reg #(.RESET_VALUE(reset_init_pkg::SHIFT_RST)) u_txs
  (
    .clk       (clk),
    .arst_n    (arst_n),
    .holdReset (holdReset),
    .wrEn      (cpuWrite.wrShift),
    .wrData    (cpuWrite.wrData),
    .value     (serial_transmit_shift_register)
  ); // [RULE_08]

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_irq
      reset_byte_reg #(.RESET_VALUE(reset_init_pkg::MASK_RST)) u_mask
      (
        .clk       (clk),
        .arst_n    (arst_n),
        .holdReset (holdReset),
        .wrEn      (cpuWrite.wrMask[g]),
        .wrData    (cpuWrite.wrData),
        .value     (interrupt_mask_register[8*g +: 8])
      ); // [RULE_06]
      reset_byte_reg #(.RESET_VALUE(reset_init_pkg::REQUEST_RST)) u_req
      (
        .clk       (clk),
        .arst_n    (arst_n),
        .holdReset (holdReset),
        .wrEn      (cpuWrite.wrRequest[g]),
        .wrData    (cpuWrite.wrData),
        .value     (interrupt_request_register[8*g +: 8])
      ); // [RULE_06]
    end
    // programming entry forces the same port state as reset [RULE_14]
    for (g = 0; g < reset_init_pkg::NUM_PORTS; g++)
    begin : g_port
      logic sel;
      assign sel = (portSel == 3'(g));
      reset_byte_reg #(.RESET_VALUE(reset_init_pkg::DIRECTION_RST)) u_dir
      (
        .clk       (clk),
        .arst_n    (arst_n),
        .holdReset (holdReset),
        .wrEn      (sel & wrDirection),
        .wrData    (cpuWrite.wrData),
        .value     (port_direction_register[8*g +: 8])
      ); // [RULE_05]
      reset_byte_reg #(.RESET_VALUE(reset_init_pkg::LATCH_RST)) u_lat
      (
        .clk       (clk),
        .arst_n    (arst_n),
        .holdReset (holdReset),
        .wrEn      (sel & wrLatch),
        .wrData    (cpuWrite.wrData),
        .value     (portOutputLatch[8*g +: 8])
      ); // [RULE_05]
    end
    // every cleared register: key return, edge modes, serial, timer, watchdog, lcd, watch timer
    for (g = 0; g < $bits(reset_init_pkg::cleared_regs_t) / 8; g++)
    begin : g_clr
      reset_byte_reg #(.RESET_VALUE(reset_init_pkg::CLEAR_RST)) u_clr
      (
        .clk       (clk),
        .arst_n    (arst_n),
        .holdReset (holdReset),
        .wrEn      (|clearedWrEn[8*g +: 8]),
        .wrData    (clearedWrData[8*g +: 8]),
        .value     (clearedRegs[8*g +: 8])
      ); // [RULE_07] [RULE_09] [RULE_10] [RULE_11] [RULE_12] [RULE_13]
    end
  endgenerate

endmodule
`default_nettype wire

// File: src/reset_init_pkg.sv
// shared constants and carrier types for the reset-state initializer
package reset_init_pkg;

  // ------------------------------------------------------------
  // reset vector and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] VECTOR_LOW_ADDR  = 16'h0000;
  localparam logic [15:0] VECTOR_HIGH_ADDR = 16'h0001;
  localparam logic [7:0]  STATUS_WORD_RST  = 8'h02;
  localparam logic [7:0]  DIRECTION_RST    = 8'hFF;
  localparam logic [7:0]  LATCH_RST        = 8'h00;
  localparam logic [7:0]  MASK_RST         = 8'hFF;
  localparam logic [7:0]  REQUEST_RST      = 8'h00;
  localparam logic [7:0]  CLEAR_RST        = 8'h00;
  localparam logic [7:0]  SHIFT_RST        = 8'hFF;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int          STAB_EXPONENT    = 15;
  localparam int          STAB_CYCLES      = 2 ** STAB_EXPONENT;
  localparam int          STAB_WIDTH       = STAB_EXPONENT + 1;
  localparam int          NUM_PORTS        = 6;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_STABILIZE,
    ST_FETCH_LOW,
    ST_FETCH_HIGH,
    ST_RUN
  } seq_state_t;

  typedef struct packed {
    logic [7:0] keyReturnMode;
    logic [7:0] extEdgeMode0;
    logic [7:0] extEdgeMode1;
    logic [7:0] asyncSerialMode;
    logic [7:0] asyncSerialStatus;
    logic [7:0] baudGenControl;
    logic [7:0] byteTimerCount;
    logic [7:0] byteTimerMode;
    logic [7:0] watchdogClockSelect;
    logic [7:0] watchdogMode;
    logic [7:0] lcdMode;
    logic [7:0] lcdClockSelect;
    logic [7:0] altFunctionSwitch;
    logic [7:0] watchTimerMode;
  } cleared_regs_t;

  typedef struct packed {
    logic [7:0] wrData;
    logic       wrStatusWord;
    logic       wrStackPointer;
    logic       wrCompare;
    logic       wrShift;
    logic [1:0] wrMask;
    logic [1:0] wrRequest;
  } cpu_write_t;

endpackage

// File: src/reset_sync.sv
// two-stage reset request synchronizer, asserts and releases on clk; only arst_n asserts it asynchronously
`timescale 1ns/1ps
`default_nettype none
module reset_sync
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic requestN,
  output var  logic syncRstN
);
  logic meta_q;
  logic meta_d;
  logic sync_d;

  always_comb
  begin
    meta_d = requestN;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q   <= 1'b0;
      syncRstN <= 1'b0;
    end
    else
    begin
      meta_q   <= meta_d;
      syncRstN <= sync_d;
    end
  end
endmodule
`default_nettype wire

// File: src/reset_byte_reg.sv
// one 8-bit register with a reset value, forced while internal reset is held
`timescale 1ns/1ps
`default_nettype none
module reset_byte_reg
#(
  parameter logic [7:0] RESET_VALUE = 8'h00
)
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       holdReset,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  output var  logic [7:0] value
);
  logic [7:0] value_d;

  always_comb
  begin
    if (holdReset)
      value_d = RESET_VALUE;
    else if (wrEn)
      value_d = wrData;
    else
      value_d = value;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      value <= RESET_VALUE;
    else
      value <= value_d;
  end
endmodule
`default_nettype wire

// File: bench/reset_state_initializer_monitor.sv
// port-level assertions for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_state_initializer_monitor
#(
  parameter int STAB_CYCLES = 16
)
(
  input wire logic                          clk,
  input wire logic                          arst_n,
  input wire logic                          resetPinN,
  input wire logic                          watchdogOverflow,
  input wire logic                          programmingEntry,
  input wire logic [7:0]                    vectorData,
  input wire logic [15:0]                   vectorAddr,
  input wire logic                          vectorRead,
  input wire logic [15:0]                   program_counter,
  input wire logic                          programCounterValid,
  input wire logic                          cpuRun,
  input wire logic                          pinsHighZ,
  input wire logic                          internalReset,
  input wire logic [7:0]                    processor_status_word,
  input wire logic [7:0]                    serial_transmit_shift_register,
  input wire logic [15:0]                   interrupt_mask_register,
  input wire logic [15:0]                   interrupt_request_register,
  input wire logic [47:0]                   port_direction_register,
  input wire logic [47:0]                   portOutputLatch,
  input wire reset_init_pkg::cleared_regs_t clearedRegs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // stabilization length seen at the pins
  // ----------------------------------------
  int stabCnt_q;
  int stabCnt_d;
  always_comb stabCnt_d = internalReset ? 0 : (pinsHighZ ? stabCnt_q + 1 : stabCnt_q);
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      stabCnt_q <= 0;
    else
      stabCnt_q <= stabCnt_d;

  sequence fetchLow;
    vectorRead && vectorAddr == 16'h0000;
  endsequence
  sequence fetchHigh;
    vectorRead && vectorAddr == 16'h0001;
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_fetch_order: assert property ($rose(vectorRead) |-> fetchLow ##1 fetchHigh ##1 cpuRun)
    else $error("vector fetch order wrong");
  chk_pc_load: assert property ($rose(programCounterValid) |->
    program_counter == {$past(vectorData), $past(vectorData, 2)}) else $error("pc load wrong");
  chk_hiz_reset: assert property (internalReset |-> pinsHighZ && !cpuRun && !programCounterValid)
    else $error("pins or pc active in reset");
  chk_run_pins: assert property (cpuRun |-> !pinsHighZ && programCounterValid)
    else $error("run without pins or pc");
  chk_stab_len: assert property ($rose(vectorRead) |-> stabCnt_q >= STAB_CYCLES)
    else $error("stabilization too short");
  chk_req_reset: assert property ((!resetPinN || watchdogOverflow || programmingEntry) |->
    ##[1:6] internalReset) else $error("reset request not taken");
  chk_wdog_release: assert property ($fell(watchdogOverflow) && resetPinN && !programmingEntry
    |-> ##[1:8] !internalReset) else $error("watchdog reset stuck");
  chk_defined_rst: assert property (internalReset |-> processor_status_word == 8'h02
    && serial_transmit_shift_register == 8'hFF && interrupt_mask_register == 16'hFFFF
    && interrupt_request_register == 16'h0000) else $error("cpu reset values wrong");
  chk_port_rst: assert property (internalReset |-> port_direction_register == {6{8'hFF}}
    && portOutputLatch == '0) else $error("port reset values wrong");
  chk_cleared_rst: assert property (internalReset |-> clearedRegs == '0)
    else $error("cleared registers not zero");
endmodule

bind reset_state_initializer reset_state_initializer_monitor #(.STAB_CYCLES(STAB_CYCLES)) mon_u
  (.clk, .arst_n, .resetPinN, .watchdogOverflow, .programmingEntry, .vectorData, .vectorAddr,
   .vectorRead, .program_counter, .programCounterValid, .cpuRun, .pinsHighZ, .internalReset,
   .processor_status_word, .serial_transmit_shift_register, .interrupt_mask_register,
   .interrupt_request_register, .port_direction_register, .portOutputLatch, .clearedRegs);
`default_nettype wire

// File: bench/reset_source_model.sv
// far side: reset pin, watchdog overflow and the reset vector bytes
`timescale 1ns/1ps
`default_nettype none
module reset_source_model
(
  input  wire logic        clk,
  input  wire logic [15:0] vectorAddr,
  input  wire logic        vectorRead,
  output var  logic        resetPinN,
  output var  logic        watchdogOverflow,
  output var  logic [7:0]  vectorData
);
  logic [7:0] vecLow = 8'h3C;
  logic [7:0] vecHigh = 8'hA5;
  logic [7:0] noise = 8'h5A;
  initial resetPinN = 1'b1;
  initial watchdogOverflow = 1'b0;
  // bus floats outside a fetch: a moving pattern keeps stale bytes from passing
  always @(posedge clk) noise <= noise + 8'h3B;
  always_comb vectorData = !vectorRead ? noise : vectorAddr == 16'h0000 ? vecLow
    : vectorAddr == 16'h0001 ? vecHigh : ~noise;
  task automatic hold_pin(input int n);
    @(negedge clk) resetPinN = 1'b0;
    repeat (n) @(negedge clk);
    resetPinN = 1'b1;
  endtask
  task automatic pulse_wdog(input int n);
    @(negedge clk) watchdogOverflow = 1'b1;
    repeat (n) @(negedge clk);
    watchdogOverflow = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: bench/reset_state_initializer_tb_top.sv
// self-checking bench for the reset sequencer against a register-level model
`timescale 1ns/1ps
`default_nettype none
module reset_state_initializer_tb_top;
  localparam int STAB = 16;
  logic clk = 1'b0;
  logic arst_n, resetPinN, watchdogOverflow, programmingEntry, wrDirection, wrLatch;
  logic vectorRead, programCounterValid, cpuRun, pinsHighZ, internalReset;
  logic [2:0] portSel;
  logic [7:0] vectorData, stack_pointer, processor_status_word, serial_transmit_shift_register;
  logic [7:0] byte_timer_compare_register, mPsw, mSp, mCmp, mShift;
  logic [15:0] vectorAddr, program_counter, interrupt_mask_register, interrupt_request_register;
  logic [15:0] mMask, mReq;
  logic [47:0] port_direction_register, portOutputLatch, mDir, mLatch;
  logic [111:0] mClr;
  reset_init_pkg::cpu_write_t cpuWrite;
  reset_init_pkg::cleared_regs_t clearedWrData, clearedWrEn, clearedRegs;
  int failures = 0;
  int compares = 0;
  int cyc = 0;

  reset_state_initializer #(.STAB_CYCLES(STAB)) dut_u
    (.clk, .arst_n, .resetPinN, .watchdogOverflow, .programmingEntry, .vectorData, .cpuWrite,
     .portSel, .wrDirection, .wrLatch, .clearedWrData, .clearedWrEn, .vectorAddr, .vectorRead,
     .program_counter, .programCounterValid, .cpuRun, .pinsHighZ, .internalReset, .stack_pointer,
     .processor_status_word, .serial_transmit_shift_register, .byte_timer_compare_register,
     .interrupt_mask_register, .interrupt_request_register, .port_direction_register,
     .portOutputLatch, .clearedRegs);
  reset_source_model srcU
    (.clk, .vectorAddr, .vectorRead, .resetPinN, .watchdogOverflow, .vectorData);

  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [111:0] exp, input logic [111:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic model_reset();
    mPsw = 8'h02;
    mShift = 8'hFF;
    mMask = 16'hFFFF;
    mReq = 16'h0000;
    mDir = {6{8'hFF}};
    mLatch = '0;
    mClr = '0;
  endtask
  task automatic check_regs();
    chk("status", 112'(mPsw), 112'(processor_status_word));
    chk("stack", 112'(mSp), 112'(stack_pointer));
    chk("compare", 112'(mCmp), 112'(byte_timer_compare_register));
    chk("shift", 112'(mShift), 112'(serial_transmit_shift_register));
    chk("mask", 112'(mMask), 112'(interrupt_mask_register));
    chk("request", 112'(mReq), 112'(interrupt_request_register));
    chk("direction", 112'(mDir), 112'(port_direction_register));
    chk("latch", 112'(mLatch), 112'(portOutputLatch));
    chk("cleared", mClr, clearedRegs);
  endtask
  // one write of kind k; apply low means the write is expected to be refused
  task automatic wr(input bit apply, input int k);
    int i;
    logic [7:0] d;
    reset_init_pkg::cpu_write_t w;
    reset_init_pkg::cleared_regs_t cd;
    reset_init_pkg::cleared_regs_t ce;
    i = $urandom_range(13);
    d = 8'($urandom);
    // strobes are built aside and driven once, so back-to-back writes never glitch low
    w = '0;
    w.wrData = d;
    w.wrStatusWord = (k == 0);
    w.wrStackPointer = (k == 1);
    w.wrCompare = (k == 2);
    w.wrShift = (k == 3);
    w.wrMask = (k == 4) ? 2'b01 << (i % 2) : 2'b00;
    w.wrRequest = (k == 5) ? 2'b01 << (i % 2) : 2'b00;
    cd = 112'({$urandom, $urandom, $urandom, $urandom});
    cd[8*i+:8] = d;
    ce = '0;
    if (k == 8) ce[8*i+:8] = 8'h80 >> (i % 8);
    @(negedge clk);
    cpuWrite = w;
    portSel = 3'(i % 6);
    wrDirection = (k == 6);
    wrLatch = (k == 7);
    clearedWrData = cd;
    clearedWrEn = ce;
    if (!apply) return;
    if (k == 0) mPsw = d;
    if (k == 1) mSp = d;
    if (k == 2) mCmp = d;
    if (k == 3) mShift = d;
    if (k == 4) mMask[8*(i%2)+:8] = d;
    if (k == 5) mReq[8*(i%2)+:8] = d;
    if (k == 6) mDir[8*(i%6)+:8] = d;
    if (k == 7) mLatch[8*(i%6)+:8] = d;
    if (k == 8) mClr[8*i+:8] = d;
  endtask
  task automatic idle();
    @(negedge clk);
    cpuWrite = '0;
    wrDirection = 1'b0;
    wrLatch = 1'b0;
    clearedWrEn = '0;
  endtask
  task automatic wait_run();
    int n;
    int t;
    n = 0;
    t = 0;
    while (cpuRun !== 1'b1 && t < 500)
    begin
      @(posedge clk);
      t++;
      if (pinsHighZ === 1'b1 && internalReset === 1'b0) n++;
    end
    @(negedge clk);
    chk("run", 112'(1), 112'(cpuRun));
    chk("stab long", 112'(1), 112'(n >= STAB));
    chk("pc", 112'({srcU.vecHigh, srcU.vecLow}), 112'(program_counter));
    chk("pc valid", 112'(1), 112'(programCounterValid));
    chk("pins", 112'(0), 112'(pinsHighZ));
  endtask
  // src 0 pin, 1 watchdog, 2 programming entry; a write lands while reset holds
  task automatic reset_by(input int src);
    {srcU.vecHigh, srcU.vecLow} = 16'($urandom);
    fork
      if (src == 0) srcU.hold_pin(8);
      else if (src == 1) srcU.pulse_wdog(8);
      else
      begin
        @(negedge clk) programmingEntry = 1'b1;
        repeat (8) @(negedge clk);
        programmingEntry = 1'b0;
      end
      begin
        repeat (6) @(negedge clk);
        // stack and compare have no reset value, so a leaked write would stay visible
        wr(1'b0, src + 1);
        idle();
      end
    join
    model_reset();
    @(negedge clk);
    check_regs();
    chk("pins hiz", 112'(1), 112'(pinsHighZ));
    chk("pc held", 112'(0), 112'(programCounterValid));
    wait_run();
  endtask

  initial
  begin
    void'($urandom(32'hb94e_8c41));
    arst_n = 1'b0;
    programmingEntry = 1'b0;
    cpuWrite = '0;
    portSel = 3'h0;
    wrDirection = 1'b0;
    wrLatch = 1'b0;
    clearedWrData = '0;
    clearedWrEn = '0;
    mSp = 'x;
    mCmp = 'x;
    model_reset();
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    wait_run();
    for (int k = 0; k < 9; k++) wr(1'b1, k);
    repeat (30) wr(1'b1, $urandom_range(8));
    idle();
    check_regs();
    for (int s = 0; s < 3; s++)
    begin
      reset_by(s);
      check_regs();
      repeat (20) wr(1'b1, $urandom_range(8));
      idle();
      check_regs();
    end
    @(negedge clk) arst_n = 1'b0;
    @(negedge clk) arst_n = 1'b1;
    model_reset();
    check_regs();
    wait_run();
    tally_and_finish();
  end
endmodule
`default_nettype wire
